// ---- verilog/shp_pkg.sv ----
// Shared constants and types for the serial register port and its master.
// Assumes a 100 MHz system clock on both ends.
`default_nettype none
package shp_pkg;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int SCLK_PERIOD_NS = 160;
   localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam int BACKUP_TIME_US = 16;
   localparam int BACKUP_CYC = BACKUP_TIME_US * 1000 / CLK_PERIOD_NS;
   // ------------------------------------------------------------
   // Device memory map
   // ------------------------------------------------------------
   localparam int MAP_SIZE = 1024;
   localparam logic [9:0] ADDR_OPSTATE = 10'h002;
   localparam logic [9:0] ADDR_DEVSTATE = 10'h003;
   localparam logic [9:0] ADDR_PINCFG = 10'h007;
   localparam int ST_INIT = 7;
   localparam int ST_OSC = 6;
   localparam int ST_CFG = 5;
   localparam int ST_CAL = 4;
   localparam int ST_OSCOFF = 3;
   localparam int ST_DEEP_SLEEP_REQUEST = 2;
   localparam int ST_IDLE = 1;
   localparam int ST_POR = 0;
   localparam logic RST_POR = 1'b1;
   // ------------------------------------------------------------
   // Master command registers
   // ------------------------------------------------------------
   localparam logic [11:0] HA_CTRL = 12'h000;
   localparam logic [11:0] HA_WDATA = 12'h004;
   localparam logic [11:0] HA_RDATA = 12'h008;
   localparam logic [11:0] HA_STAT = 12'h00C;
   localparam int C_LONG = 10;
   localparam int C_WR = 11;
   localparam int C_MOD = 12;
   localparam int C_LEN = 16;
   // ------------------------------------------------------------
   // States
   // ------------------------------------------------------------
   typedef enum logic [1:0] {DS_CMD, DS_LADDR, DS_DATA} shp_dev_state_t;
   typedef enum logic [2:0] {
      HS_IDLE, HS_LOW, HS_HIGH, HS_WAIT, HS_TAIL, HS_GAP
   } shp_host_state_t;
endpackage : shp_pkg
`default_nettype wire

// ---- verilog/shp_spi_if.sv ----
// Four-wire serial link between the master and the register port.
// Assumes the master alone drives clock, select and data out.
`timescale 1ns/1ps
`default_nettype none
interface shp_spi_if;
   logic sclk;
   logic cs_n;
   logic mosi;
   logic miso;
   modport dev (input sclk, input cs_n, input mosi, output miso);
   modport host (output sclk, output cs_n, output mosi, input miso);
endinterface : shp_spi_if
`default_nettype wire

// ---- verilog/shp_device.sv ----
// Serial register port of the transceiver with its status registers.
// Assumes core status inputs are on i_clock; link pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module shp_device (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // Serial link
   shp_spi_if.dev spi,
   // Core state
   input wire logic [2:0] i_mac_state_code,
   input wire logic [2:0] i_radio_state_code,
   input wire logic [4:0] i_busy,
   input wire logic i_osc_running,
   // Core events
   input wire logic i_rx_frame_done,
   input wire logic i_ready_event,
   input wire logic i_regulator_on_event,
   input wire logic i_calibration_advised_event,
   input wire logic i_calibration_required_event,
   input wire logic i_cal_done,
   input wire logic i_cal_fail,
   // Core controls
   output logic o_tx_launch,
   output logic o_osc_enable,
   output logic o_regulator_on,
   output logic o_cal_run,
   output logic o_cal_failed,
   output logic [2:0] o_gpio
);
   // ------------------------------------------------------------
   // Pin synchronisers and edges
   // ------------------------------------------------------------
   logic [1:0] sclk_s, cs_s, mosi_s;
   logic sclk_p_q, cs_p_q;
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         sclk_s <= 2'h0;
         cs_s <= 2'h3;
         mosi_s <= 2'h0;
         sclk_p_q <= 1'b0;
         cs_p_q <= 1'b1;
      end
      else
      begin
         sclk_s <= {sclk_s[0], spi.sclk};
         cs_s <= {cs_s[0], spi.cs_n};
         mosi_s <= {mosi_s[0], spi.mosi};
         sclk_p_q <= sclk_s[1];
         cs_p_q <= cs_s[1];
      end
   end
   logic rise, fall, cs_start, cs_end;
   assign rise = sclk_s[1] & ~sclk_p_q & ~cs_s[1];
   assign fall = ~sclk_s[1] & sclk_p_q & ~cs_s[1];
   assign cs_start = ~cs_s[1] & cs_p_q;
   assign cs_end = cs_s[1] & ~cs_p_q;

   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   logic [7:0] mem [0:shp_pkg::MAP_SIZE-1];
   logic init_q, regon_seen_q, osc_stable_q, cfg_valid_q, cal_go_q;
   logic osc_off_q, deep_sleep_request_q, idle_q, por_q, pinsel_q, rx_full_q;
   logic cal_pend_q, sleep_q, restoring_q;
   logic [10:0] bk_cnt_q;
   logic [7:0] opstate, devstate;
   assign opstate = {1'b0, i_mac_state_code, rx_full_q,
      i_radio_state_code};
   assign devstate = {init_q, osc_stable_q, cfg_valid_q, cal_go_q,
      osc_off_q, deep_sleep_request_q, idle_q, por_q};

   function automatic logic [7:0] rd_byte(input logic [9:0] a);
      logic [7:0] v;
      v = mem[a];
      if (a == shp_pkg::ADDR_OPSTATE)
         v = opstate;
      else if (a == shp_pkg::ADDR_DEVSTATE)
         v = devstate;
      else if (a == shp_pkg::ADDR_PINCFG)
         v = {7'h00, pinsel_q};
      return v;
   endfunction : rd_byte

   // ------------------------------------------------------------
   // Byte framing
   // ------------------------------------------------------------
   shp_pkg::shp_dev_state_t state_q;
   logic [2:0] bit_q;
   logic [7:0] rx_q, rx_d, tx_q;
   logic [9:0] addr_q, nxt_addr;
   logic wr_q, mod_q, flush_q, launch_q, miso_q, blocked, done;
   assign rx_d = {rx_q[6:0], mosi_s[1]};
   assign done = rise & (bit_q == 3'h7);
   assign blocked = deep_sleep_request_q | sleep_q;
   always_comb
   begin
      unique case (state_q)
         shp_pkg::DS_CMD:
            nxt_addr = rx_d[7] ? {rx_d[6:0], 3'h0}
               : {4'h0, rx_d[6:1]};
         shp_pkg::DS_LADDR:
            nxt_addr = {addr_q[9:3], rx_d[7:5]};
         shp_pkg::DS_DATA:
            nxt_addr = addr_q + 10'h001;
         default:
            nxt_addr = addr_q;
      endcase
   end
   logic wr_fire;
   assign wr_fire = done & (state_q == shp_pkg::DS_DATA) & wr_q
      & ~blocked;

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         state_q <= shp_pkg::DS_CMD;
         bit_q <= 3'h0;
         rx_q <= 8'h00;
         addr_q <= 10'h000;
         wr_q <= 1'b0;
         mod_q <= 1'b0;
      end
      else if (cs_s[1])
      begin
         state_q <= shp_pkg::DS_CMD;
         bit_q <= 3'h0;
      end
      else if (rise)
      begin
         rx_q <= rx_d;
         bit_q <= bit_q + 3'h1;
         if (done)
         begin
            addr_q <= nxt_addr;
            unique case (state_q)
               shp_pkg::DS_CMD:
               begin
                  wr_q <= rx_d[0];
                  mod_q <= 1'b0;
                  state_q <= rx_d[7] ? shp_pkg::DS_LADDR
                     : shp_pkg::DS_DATA;
               end
               shp_pkg::DS_LADDR:
               begin
                  wr_q <= rx_d[4];
                  mod_q <= rx_d[3];
                  state_q <= shp_pkg::DS_DATA;
               end
               shp_pkg::DS_DATA:
                  state_q <= shp_pkg::DS_DATA;
               default:
                  state_q <= shp_pkg::DS_CMD;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // Serial output
   // ------------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         miso_q <= 1'b0;
         tx_q <= 8'h00;
      end
      else if (cs_start)
      begin
         miso_q <= opstate[7];
         tx_q <= {opstate[6:0], 1'b0};
      end
      else if (done)
         tx_q <= blocked ? 8'h00 : rd_byte(nxt_addr);
      else if (fall)
      begin
         miso_q <= tx_q[7];
         tx_q <= {tx_q[6:0], 1'b0};
      end
   end
   assign spi.miso = miso_q;

   // ------------------------------------------------------------
   // Memory and pin configuration
   // ------------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         for (int i = 0; i < shp_pkg::MAP_SIZE; i++)
            mem[i] <= 8'h00;
         pinsel_q <= 1'b0;
      end
      else if (wr_fire)
      begin
         mem[addr_q] <= rx_d;
         if (addr_q == shp_pkg::ADDR_PINCFG)
            pinsel_q <= rx_d[0];
      end
   end

   // ------------------------------------------------------------
   // Buffer flush and transmit launch at select release
   // ------------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         flush_q <= 1'b0;
         launch_q <= 1'b0;
         rx_full_q <= 1'b0;
         o_tx_launch <= 1'b0;
      end
      else
      begin
         o_tx_launch <= cs_end & launch_q;
         if (cs_end)
         begin
            flush_q <= 1'b0;
            launch_q <= 1'b0;
         end
         else if (done & (state_q == shp_pkg::DS_DATA) & mod_q
            & ~blocked)
         begin
            flush_q <= flush_q | ~wr_q;
            launch_q <= launch_q | wr_q;
         end
         if (i_rx_frame_done)
            rx_full_q <= 1'b1;
         else if (cs_end & flush_q)
            rx_full_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Device status bits
   // ------------------------------------------------------------
   logic st_wr;
   assign st_wr = wr_fire & (addr_q == shp_pkg::ADDR_DEVSTATE);
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         regon_seen_q <= 1'b0;
         init_q <= 1'b0;
         osc_off_q <= 1'b0;
         osc_stable_q <= 1'b0;
         idle_q <= 1'b0;
         por_q <= shp_pkg::RST_POR;
         o_osc_enable <= 1'b0;
         o_gpio <= 3'h0;
      end
      else
      begin
         if (i_regulator_on_event)
            regon_seen_q <= 1'b1;
         if (i_ready_event & regon_seen_q)
            init_q <= 1'b1;
         if (st_wr)
         begin
            osc_off_q <= rx_d[shp_pkg::ST_OSCOFF];
            por_q <= rx_d[shp_pkg::ST_POR];
         end
         osc_stable_q <= i_osc_running & ~osc_off_q;
         o_osc_enable <= ~osc_off_q;
         idle_q <= ~|i_busy;
         o_gpio <= pinsel_q ? i_radio_state_code
            : i_mac_state_code;
      end
   end

   // ------------------------------------------------------------
   // Calibration
   // ------------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cal_go_q <= 1'b0;
         cal_pend_q <= 1'b0;
         o_cal_run <= 1'b0;
         o_cal_failed <= 1'b0;
      end
      else
      begin
         if (i_calibration_advised_event | i_calibration_required_event)
            cal_pend_q <= 1'b1;
         else if (cal_go_q & ~o_cal_run)
            cal_pend_q <= 1'b0;
         if (st_wr & rx_d[shp_pkg::ST_CAL])
            cal_go_q <= 1'b1;
         else if (cal_go_q & ~o_cal_run & ~cal_pend_q)
            cal_go_q <= 1'b0;
         else if (o_cal_run & i_cal_done)
            cal_go_q <= 1'b0;
         if (cal_go_q & ~o_cal_run & cal_pend_q)
            o_cal_run <= 1'b1;
         else if (o_cal_run & i_cal_done)
         begin
            o_cal_run <= 1'b0;
            o_cal_failed <= i_cal_fail;
         end
      end
   end

   // ------------------------------------------------------------
   // Deep sleep, backup and restore
   // ------------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         deep_sleep_request_q <= 1'b0;
         sleep_q <= 1'b0;
         restoring_q <= 1'b0;
         bk_cnt_q <= 11'h000;
         cfg_valid_q <= 1'b0;
         o_regulator_on <= 1'b1;
      end
      else
      begin
         cfg_valid_q <= ~restoring_q & ~sleep_q;
         if (st_wr & rx_d[shp_pkg::ST_DEEP_SLEEP_REQUEST])
            deep_sleep_request_q <= 1'b1;
         else if (sleep_q & cs_start)
         begin
            sleep_q <= 1'b0;
            deep_sleep_request_q <= 1'b0;
            restoring_q <= 1'b1;
            o_regulator_on <= 1'b1;
            bk_cnt_q <= 11'h000;
         end
         else if ((deep_sleep_request_q & ~sleep_q) | restoring_q)
         begin
            if (bk_cnt_q == 11'(shp_pkg::BACKUP_CYC - 1))
            begin
               bk_cnt_q <= 11'h000;
               sleep_q <= ~restoring_q;
               o_regulator_on <= restoring_q;
               restoring_q <= 1'b0;
            end
            else
               bk_cnt_q <= bk_cnt_q + 11'h001;
         end
      end
   end
endmodule : shp_device
`default_nettype wire

// ---- verilog/shp_host.sv ----
// Serial link master taking its orders from software over APB.
// Assumes a single register-port device on the link.
`timescale 1ns/1ps
`default_nettype none
module shp_host (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Serial link
   shp_spi_if.host spi
);
   // ------------------------------------------------------------
   // APB access
   // ------------------------------------------------------------
   logic setup, acc, mapped;
   logic busy_q, wfull_q, rvalid_q, long_q, wr_q, mod_q;
   logic [9:0] addr_q;
   logic [7:0] len_q, wdat_q, rdat_q, stat_q;
   assign setup = i_psel & ~i_penable;
   assign acc = i_psel & i_penable & o_pready;
   assign mapped = (i_paddr == shp_pkg::HA_CTRL)
      | (i_paddr == shp_pkg::HA_WDATA) | (i_paddr == shp_pkg::HA_RDATA)
      | (i_paddr == shp_pkg::HA_STAT);

   function automatic logic [31:0] rd_word(input logic [11:0] a);
      logic [31:0] v;
      v = 32'h0000_0000;
      if (a == shp_pkg::HA_CTRL)
         v = {8'h00, len_q, 3'h0, mod_q, wr_q, long_q, addr_q};
      else if (a == shp_pkg::HA_WDATA)
         v = {24'h00_0000, wdat_q};
      else if (a == shp_pkg::HA_RDATA)
         v = {24'h00_0000, rdat_q};
      else if (a == shp_pkg::HA_STAT)
         v = {16'h0000, stat_q, 5'h00, wfull_q, rvalid_q, busy_q};
      return v;
   endfunction : rd_word

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= 32'h0000_0000;
      end
      else
      begin
         o_pready <= setup;
         o_pslverr <= setup & ~mapped;
         o_prdata <= (setup & ~i_pwrite) ? rd_word(i_paddr)
            : 32'h0000_0000;
      end
   end

   logic start, wd_wr, rd_rd, rx_set, consume;
   assign start = acc & i_pwrite & (i_paddr == shp_pkg::HA_CTRL) & ~busy_q;
   assign wd_wr = acc & i_pwrite & (i_paddr == shp_pkg::HA_WDATA);
   assign rd_rd = acc & ~i_pwrite & (i_paddr == shp_pkg::HA_RDATA);

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         wdat_q <= 8'h00;
         wfull_q <= 1'b0;
         rvalid_q <= 1'b0;
      end
      else
      begin
         if (wd_wr)
            wdat_q <= i_pwdata[7:0];
         wfull_q <= wd_wr | (wfull_q & ~consume);
         rvalid_q <= rx_set | (rvalid_q & ~rd_rd);
      end
   end

   // ------------------------------------------------------------
   // Link engine
   // ------------------------------------------------------------
   shp_pkg::shp_host_state_t st_q;
   logic [1:0] miso_s;
   logic [3:0] cnt_q;
   logic [2:0] bit_q;
   logic [8:0] byte_q, total;
   logic [7:0] sh_q, rsh_q, rx_d, cmd1, nxt;
   logic sclk_q, cs_n_q, mosi_q, half, is_data, can_go;
   assign half = cnt_q == 4'(shp_pkg::SCLK_HALF_CYC - 1);
   assign rx_d = {rsh_q[6:0], miso_s[1]};
   assign total = {1'b0, len_q} + (long_q ? 9'h002 : 9'h001);
   assign is_data = byte_q >= (long_q ? 9'h002 : 9'h001);
   assign cmd1 = i_pwdata[shp_pkg::C_LONG] ? {1'b1, i_pwdata[9:3]}
      : {1'b0, i_pwdata[5:0], i_pwdata[shp_pkg::C_WR]};
   assign nxt = !is_data ? {addr_q[2:0], wr_q, mod_q, 3'h0}
      : (wr_q ? wdat_q : 8'h00);
   assign can_go = !is_data | (wr_q ? wfull_q : ~rvalid_q);
   assign consume = (st_q == shp_pkg::HS_WAIT) & is_data & wr_q & wfull_q;
   assign rx_set = (st_q == shp_pkg::HS_HIGH) & half & (bit_q == 3'h0)
      & is_data & ~wr_q;

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
         miso_s <= 2'h0;
      else
         miso_s <= {miso_s[0], spi.miso};
   end

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         st_q <= shp_pkg::HS_IDLE;
         cnt_q <= 4'h0;
         bit_q <= 3'h0;
         byte_q <= 9'h000;
         sh_q <= 8'h00;
         rsh_q <= 8'h00;
         rdat_q <= 8'h00;
         stat_q <= 8'h00;
         addr_q <= 10'h000;
         len_q <= 8'h00;
         long_q <= 1'b0;
         wr_q <= 1'b0;
         mod_q <= 1'b0;
         busy_q <= 1'b0;
         sclk_q <= 1'b0;
         cs_n_q <= 1'b1;
         mosi_q <= 1'b0;
      end
      else
      begin
         cnt_q <= half ? 4'h0 : cnt_q + 4'h1;
         unique case (st_q)
            shp_pkg::HS_IDLE:
            begin
               cnt_q <= 4'h0;
               if (start)
               begin
                  addr_q <= i_pwdata[9:0];
                  long_q <= i_pwdata[shp_pkg::C_LONG];
                  wr_q <= i_pwdata[shp_pkg::C_WR];
                  mod_q <= i_pwdata[shp_pkg::C_MOD];
                  len_q <= i_pwdata[shp_pkg::C_LEN+:8];
                  busy_q <= 1'b1;
                  cs_n_q <= 1'b0;
                  sh_q <= cmd1;
                  mosi_q <= cmd1[7];
                  bit_q <= 3'h7;
                  byte_q <= 9'h000;
                  st_q <= shp_pkg::HS_LOW;
               end
            end
            shp_pkg::HS_LOW:
               if (half)
               begin
                  sclk_q <= 1'b1;
                  rsh_q <= rx_d;
                  st_q <= shp_pkg::HS_HIGH;
               end
            shp_pkg::HS_HIGH:
               if (half)
               begin
                  sclk_q <= 1'b0;
                  if (bit_q != 3'h0)
                  begin
                     bit_q <= bit_q - 3'h1;
                     sh_q <= {sh_q[6:0], 1'b0};
                     mosi_q <= sh_q[6];
                     st_q <= shp_pkg::HS_LOW;
                  end
                  else
                  begin
                     if (byte_q == 9'h000)
                        stat_q <= rsh_q;
                     if (rx_set)
                        rdat_q <= rsh_q;
                     byte_q <= byte_q + 9'h001;
                     st_q <= (byte_q + 9'h001 == total)
                        ? shp_pkg::HS_TAIL : shp_pkg::HS_WAIT;
                  end
               end
            shp_pkg::HS_WAIT:
            begin
               cnt_q <= 4'h0;
               if (can_go)
               begin
                  sh_q <= nxt;
                  mosi_q <= nxt[7];
                  bit_q <= 3'h7;
                  st_q <= shp_pkg::HS_LOW;
               end
            end
            shp_pkg::HS_TAIL:
               if (half)
               begin
                  cs_n_q <= 1'b1;
                  st_q <= shp_pkg::HS_GAP;
               end
            shp_pkg::HS_GAP:
               if (half)
               begin
                  busy_q <= 1'b0;
                  mosi_q <= 1'b0;
                  st_q <= shp_pkg::HS_IDLE;
               end
            default:
               st_q <= shp_pkg::HS_IDLE;
         endcase
      end
   end
   assign spi.sclk = sclk_q;
   assign spi.cs_n = cs_n_q;
   assign spi.mosi = mosi_q;
endmodule : shp_host
`default_nettype wire

// ---- dv/shp_link_monitor.sv ----
// Checker of the link wires between master and register port.
// Assumes mode 0 framing with an eight-cycle half period.
`timescale 1ns/1ps
`default_nettype none
module shp_link_monitor (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // Link wires
   input wire logic i_sclk,
   input wire logic i_cs_n,
   input wire logic i_mosi,
   input wire logic i_miso
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   idle_low_a: assert property (i_cs_n |-> !i_sclk)
      else $error("Link clock high while deselected.");
   mosi_hold_a: assert property ($rose(i_sclk) |-> $stable(i_mosi))
      else $error("Master data moved at a rising link clock.");
   miso_hold_a: assert property ($rose(i_sclk) |-> $stable(i_miso))
      else $error("Port data moved at a rising link clock.");
   high_len_a: assert property ($rose(i_sclk) |->
      i_sclk[*8] ##1 !i_sclk)
      else $error("Link clock high phase has the wrong length.");
   low_len_a: assert property ($fell(i_sclk) |-> (!i_sclk)[*8])
      else $error("Link clock low phase too short.");
   sel_lead_a: assert property ($fell(i_cs_n) |->
      (!i_sclk)[*8] ##1 i_sclk)
      else $error("Select lead time wrong.");
   desel_gap_a: assert property ($rose(i_cs_n) |-> i_cs_n[*8])
      else $error("Deselect gap too short.");
   release_low_a: assert property ($rose(i_cs_n) |-> !$past(i_sclk))
      else $error("Select released with link clock high.");
endmodule : shp_link_monitor
`default_nettype wire

// ---- dv/testbench.sv ----
// Bench: APB orders to the link master, which reaches the register port.
// Assumes both design ends joined by the link interface.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic c = 0, r = 0, ps = 0, pe = 0, pw = 0, rx = 0, rdy, tx;
   logic osc = 1, er, rer, oe, ro, cr, cf;
   logic [2:0] mac, rad, gp;
   logic [4:0] bz = 0, ev = 0;
   logic [7:0] mem [1024], st;
   logic [11:0] pa = 0;
   logic [31:0] wd = 0, prd, rdat, sd = 32'hE54E, q [$];
   int error_cnt = 0, n_compared = 0, nl = 0;
   shp_spi_if lk();
   shp_device u_shp_device(.i_clock(c), .i_rst_n(r), .spi(lk), .i_busy(bz),
      .i_mac_state_code(mac), .i_radio_state_code(rad), .i_osc_running(osc),
      .i_rx_frame_done(rx), .i_ready_event(ev[0]), .i_cal_fail(1'b0),
      .i_regulator_on_event(ev[1]), .i_calibration_advised_event(ev[2]),
      .i_calibration_required_event(ev[3]), .i_cal_done(ev[4]), .o_gpio(gp),
      .o_tx_launch(tx), .o_osc_enable(oe), .o_regulator_on(ro),
      .o_cal_run(cr), .o_cal_failed(cf));
   shp_host u_shp_host(.i_clock(c), .i_rst_n(r), .i_psel(ps), .i_penable(pe),
      .i_pwrite(pw), .i_paddr(pa), .i_pwdata(wd), .o_prdata(prd),
      .o_pready(rdy), .o_pslverr(er), .spi(lk));
   shp_link_monitor u_shp_link_monitor(.i_clock(c), .i_rst_n(r),
      .i_sclk(lk.sclk), .i_cs_n(lk.cs_n), .i_mosi(lk.mosi),
      .i_miso(lk.miso));
   always #5 c = ~c;
   always @(posedge c) if (tx) nl++;
   always @(posedge c)
      if (ps && pe && rdy && q.size() != 0) cmp(prd, q.pop_front());
   initial
   begin
      #400000 error_cnt++;
      stop_test;
   end
   function automatic logic [31:0] lf(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lf
   task automatic cmp(input logic [31:0] g, input logic [31:0] x);
      n_compared++;
      error_cnt += int'(g !== x);
      if (g !== x) $display("ERROR %0t %h %h", $time, g, x);
   endtask : cmp
   task stop_test;
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : stop_test
   task automatic apb(input logic w, logic [11:0] a, logic [31:0] d);
      {ps, pw, pa, wd} <= {1'b1, w, a, d};
      @(posedge c);
      pe <= 1'b1;
      do @(posedge c); while (!rdy);
      rdat = prd;
      rer = er;
      {ps, pe} <= 2'h0;
      @(posedge c);
   endtask : apb
   // Mode m is {modifier, write, long}; write data is random unless fx >= 0.
   task automatic xfer(input logic [9:0] a, logic [2:0] m, int n,
      int fx = -1);
      logic [7:0] d;
      apb(1'b1, 12'h0, {8'h0, 8'(n), 3'h0, m, a});
      for (int i = 0; i < n; i++)
      begin
         sd = lf(sd);
         d = (fx < 0) ? sd[7:0] : 8'(fx);
         if (m[1]) mem[a + 10'(i)] = d;
         do apb(1'b0, 12'hC, 32'h0); while (rdat[2:1] !== {1'b0, !m[1]});
         if (!m[1]) q.push_back({24'h0, mem[a + 10'(i)]});
         apb(m[1], m[1] ? 12'h4 : 12'h8, {24'h0, d});
      end
      do apb(1'b0, 12'hC, 32'h0); while (rdat[0] !== 1'b0);
      q.push_back({16'h0, st, 8'h0});
      apb(1'b0, 12'hC, 32'h0);
   endtask : xfer
   initial
   begin
      sd = lf(sd);
      st = {1'b0, sd[5:3], 1'b0, sd[2:0]};
      repeat (4) @(posedge c);
      r <= 1'b1;
      {mac, rad} <= sd[5:0];
      repeat (4) @(posedge c);
      xfer(10'h03E, 3'b010, 2);
      xfer(10'h03E, 3'b000, 2);
      xfer(10'h3FF, 3'b011, 3);
      xfer(10'h3FF, 3'b001, 3);
      {rx, st[3]} <= 2'b11;
      @(posedge c);
      rx <= 1'b0;
      xfer(10'h3FF, 3'b101, 1);
      st[3] = 1'b0;
      xfer(10'h03E, 3'b000, 1);
      xfer(10'h101, 3'b111, 1);
      cmp(nl, 1);
      xfer(10'h007, 3'b010, 1);
      cmp(gp, mem[7][0] ? rad : mac);
      $display("link test done");
      mem[3] = 8'h63;
      xfer(10'h003, 3'b000, 1);
      {osc, bz, ev} <= {1'b0, sd[8:4] | 5'h01, 5'h02};
      @(posedge c);
      ev <= 5'h01;
      @(posedge c);
      ev <= 5'h00;
      mem[3] = 8'hA1;
      xfer(10'h003, 3'b001, 1);
      xfer(10'h003, 3'b010, 1, 8'h19);
      mem[3] = 8'hA9;
      xfer(10'h003, 3'b000, 1);
      cmp({oe, ro, cr, cf}, 4'h4);
      apb(1'b0, 12'h010, 32'h0);
      cmp({31'h0, rer}, 32'h1);
      cmp(rdat, 32'h0);
      $display("status test done");
      stop_test;
   end
endmodule : testbench
`default_nettype wire
